// File: pkg/sbsram_pkg.sv
// Purpose: Constants for the synchronous burst static memory model
// Assumes: One clock clk_sys at 50 MHz, synchronous active-low reset
// Notes:   Operation list below; tags mark the logic in the design files
//
// Operation
// [RQ1] Burst steps only two low address bits
// [RQ2] Load-low edge ends any running burst
// [RQ3] Read/write ignored while advancing a burst
// [RQ4] Burst direction fixed at address load
// [RQ5] Read/write low on load starts write
// [RQ6] Controller gives byte selects one cycle early
// [RQ7] Controller drives byte selects every write cycle
// [RQ8] Suspend high freezes every internal register; code keeps pin synchronisers, wr_stall and output-enable release running
// [RQ9] Any inactive chip select starts deselect
// [RQ10] Data bus released one cycle after deselect
// [RQ11] Pending transfer completes before bus release
// [RQ12] Third chip select is active high
// [RQ13] Write data captured on following edge
// [RQ14] Selected only when all three selects active
// [RQ15] Read data flows through; enable forces release
// [RQ16] Interleaved xor order or linear increment
package sbsram_pkg;
    localparam int SBS_ADDR_W  = 17;
    localparam int SBS_DATA_W  = 36;
    localparam int SBS_LANES   = 4;
    localparam int SBS_LANE_W  = 9;
    localparam int SBS_BURST_W = 2;
    localparam int SBS_CLK_MHZ = 50;
endpackage

// File: pkg/sbsram_wr_if.sv
// Purpose: Carries one write beat between the core and its buffer
// Assumes: Single clock domain
// Notes:   Valid/ready handshake on both sides
`timescale 1ns/1ps
`default_nettype none
interface sbsram_wr_if
    import sbsram_pkg::*;
#(
    parameter int AW = SBS_ADDR_W,
    parameter int DW = SBS_DATA_W,
    parameter int NL = SBS_LANES
);
    logic          valid;
    logic          ready;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [NL-1:0] lane_wr;
    modport src (output valid, output addr, output data, output lane_wr, input ready);
    modport dst (input valid, input addr, input data, input lane_wr, output ready);
endinterface
`default_nettype wire

// File: rtl/sbsram_wbuf.sv
// Purpose: Two-entry buffer between write capture and the storage array
// Assumes: Same clock as the core; suspend stalls both sides
// Notes:   Ready low when full; source must hold beats while ready low
`timescale 1ns/1ps
`default_nettype none
module sbsram_wbuf
    import sbsram_pkg::*;
#(
    parameter int AW = SBS_ADDR_W,
    parameter int DW = SBS_DATA_W,
    parameter int NL = SBS_LANES
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic hold,
    sbsram_wr_if.dst  up,
    sbsram_wr_if.src  dn
);
    localparam int EW = AW + DW + NL;
    logic [EW-1:0] mem_reg [2];
    logic          wp_reg;
    logic          rp_reg;
    logic [1:0]    cnt_reg;
    logic          push;
    logic          pop;

    // Handshake terms; suspend freezes the whole buffer
    assign up.ready = (cnt_reg != 2'h2) && !hold;
    assign dn.valid = (cnt_reg != 2'h0) && !hold;
    assign push     = up.valid && up.ready;
    assign pop      = dn.valid && dn.ready;
    assign {dn.addr, dn.data, dn.lane_wr} = mem_reg[rp_reg];

    // Entry storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wp_reg] <= {up.addr, up.data, up.lane_wr};
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) begin
                wp_reg <= ~wp_reg;
            end
            if (pop) begin
                rp_reg <= ~rp_reg;
            end
            cnt_reg <= 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule
`default_nettype wire

// File: rtl/sbsram_core.sv
// Purpose: Memory-side logic of a flow-through synchronous burst SRAM
// Assumes: Controller keeps byte-select timing; one clock clk_sys
// Notes:   Data bus pins split into in, out and low-active output enable
`timescale 1ns/1ps
`default_nettype none
module sbsram_core
    import sbsram_pkg::*;
#(
    parameter int AW    = SBS_ADDR_W,
    parameter int DW    = SBS_DATA_W,
    parameter int NL    = SBS_LANES,
    parameter int LW    = SBS_LANE_W,
    parameter int DEPTH = 64
) (
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic          rd_wr_n,
    input  wire logic          advance_or_load_select,
    input  wire logic          clock_suspend_n,
    input  wire logic          chip_select_a_n,
    input  wire logic          chip_select_c_n,
    input  wire logic          chip_select_b,
    input  wire logic          burst_order_select,
    input  wire logic [NL-1:0] lane_wr_n,
    input  wire logic          out_enable_n,
    input  wire logic [DW-1:0] dq_in,
    output logic      [DW-1:0] dq_out,
    output logic               dq_oe_n,
    output logic               wr_stall
);
    typedef enum logic [1:0] {
        SBS_IDLE  = 2'b00,
        SBS_READ  = 2'b01,
        SBS_WRITE = 2'b10
    } sbs_op_t;

    localparam int IW = $clog2(DEPTH);

    // Pin synchronisers (two stages each)
    logic [AW-1:0] a_s1, a_s2;
    logic          rw_s1, rw_s2, adv_s1, adv_s2, sus_s1, sus_s2;
    logic [2:0]    cs_s1, cs_s2;
    logic          lbo_s1, lbo_s2, oe_s1, oe_s2;
    logic [NL-1:0] bw_s1, bw_s2;
    logic [DW-1:0] d_s1, d_s2;

    always_ff @(posedge clk_sys) begin
        a_s1   <= addr_in;
        a_s2   <= a_s1;
        rw_s1  <= rd_wr_n;
        rw_s2  <= rw_s1;
        adv_s1 <= advance_or_load_select;
        adv_s2 <= adv_s1;
        sus_s1 <= clock_suspend_n;
        sus_s2 <= sus_s1;
        cs_s1  <= {chip_select_b, chip_select_c_n, chip_select_a_n};
        cs_s2  <= cs_s1;
        lbo_s1 <= burst_order_select;
        lbo_s2 <= lbo_s1;
        oe_s1  <= out_enable_n;
        oe_s2  <= oe_s1;
        bw_s1  <= lane_wr_n;
        bw_s2  <= bw_s1;
        d_s1   <= dq_in;
        d_s2   <= d_s1;
    end

    // Decoded controls of the sampled edge
    logic edge_on;
    logic selected;
    logic load;
    logic stall;
    // [RQ8] Suspend blocks edge
    assign edge_on  = !sus_s2 && !stall;
    // [RQ12] [RQ14] Select polarity
    assign selected = !cs_s2[0] && !cs_s2[1] && cs_s2[2];
    // [RQ2] Load ends burst
    assign load     = !adv_s2;

    // Address / burst state
    sbs_op_t             op_reg;
    logic [AW-1:0]       base_reg;
    logic [SBS_BURST_W-1:0] cnt_reg;
    logic                lbo_reg;
    // Data-phase pipeline: operation and address one cycle late
    sbs_op_t             dop_reg;
    logic [AW-1:0]       daddr_reg;
    logic [NL-1:0]       dbw_reg;

    // Current burst address from base and count
    logic [SBS_BURST_W-1:0] low_bits;
    logic [AW-1:0]          cur_addr;
    logic [SBS_BURST_W-1:0] cnt_next;
    // [RQ16] Interleaved or linear
    assign low_bits = lbo_reg ? (base_reg[SBS_BURST_W-1:0] ^ cnt_next)
                              : SBS_BURST_W'(base_reg[SBS_BURST_W-1:0] + cnt_next);
    assign cnt_next = SBS_BURST_W'(cnt_reg + 2'h1);
    // [RQ1] Only low bits advance
    assign cur_addr = {base_reg[AW-1:SBS_BURST_W], low_bits};

    // Address phase: load, advance or deselect
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            op_reg   <= SBS_IDLE;
            base_reg <= '0;
            cnt_reg  <= '0;
            lbo_reg  <= 1'b0;
        end else if (edge_on) begin
            if (load) begin
                base_reg <= a_s2;
                cnt_reg  <= '0;
                lbo_reg  <= lbo_s2;
                // [RQ9] Deselect on load
                if (!selected) begin
                    op_reg <= SBS_IDLE;
                // [RQ4] [RQ5] Direction latched
                end else if (!rw_s2) begin
                    op_reg <= SBS_WRITE;
                end else begin
                    op_reg <= SBS_READ;
                end
            // [RQ3] Advance ignores read/write
            end else if (op_reg != SBS_IDLE) begin
                cnt_reg <= cnt_next;
            end
        end
    end

    // Address of this edge's operation
    logic [AW-1:0] op_addr;
    sbs_op_t       op_now;
    always_comb begin
        op_addr = a_s2;
        op_now  = SBS_IDLE;
        if (load) begin
            if (selected) begin
                op_now = rw_s2 ? SBS_READ : SBS_WRITE;
            end
        end else if (op_reg != SBS_IDLE) begin
            op_addr = cur_addr;
            op_now  = op_reg;
        end
    end

    // Data phase register: byte selects come with the address
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dop_reg   <= SBS_IDLE;
            daddr_reg <= '0;
            dbw_reg   <= '0;
        end else if (edge_on) begin
            dop_reg   <= op_now;
            daddr_reg <= op_addr;
            // [RQ6] [RQ7] Selects one early
            dbw_reg   <= ~bw_s2;
        end
    end

    // Write capture into the buffer on the following edge
    sbsram_wr_if #(.AW(AW), .DW(DW), .NL(NL)) wr_up ();
    sbsram_wr_if #(.AW(AW), .DW(DW), .NL(NL)) wr_dn ();
    // [RQ11] [RQ13] Pending write captured
    assign wr_up.valid   = edge_on && (dop_reg == SBS_WRITE);
    assign wr_up.addr    = daddr_reg;
    assign wr_up.data    = d_s2;
    assign wr_up.lane_wr = dbw_reg;
    assign stall         = (dop_reg == SBS_WRITE) && !wr_up.ready;
    assign wr_dn.ready   = 1'b1;

    sbsram_wbuf #(.AW(AW), .DW(DW), .NL(NL)) u_wbuf (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .hold    (sus_s2),
        .up      (wr_up),
        .dn      (wr_dn)
    );

    // Storage array with byte-lane writes
    logic [DW-1:0] mem [DEPTH];
    genvar gl;
    generate
        for (gl = 0; gl < NL; gl++) begin : g_lane
            always_ff @(posedge clk_sys) begin
                if (wr_dn.valid && wr_dn.lane_wr[gl]) begin
                    mem[wr_dn.addr[IW-1:0]][gl*LW +: LW] <= wr_dn.data[gl*LW +: LW];
                end
            end
        end
    endgenerate

    // Read forwarding from buffered writes not yet in the array
    logic [DW-1:0] rd_word;
    always_comb begin
        rd_word = mem[op_addr[IW-1:0]];
        if (wr_dn.valid && wr_dn.addr == op_addr) begin
            for (int i = 0; i < NL; i++) begin
                if (wr_dn.lane_wr[i]) begin
                    rd_word[i*LW +: LW] = wr_dn.data[i*LW +: LW];
                end
            end
        end
        if (wr_up.valid && wr_up.addr == op_addr) begin
            for (int i = 0; i < NL; i++) begin
                if (wr_up.lane_wr[i]) begin
                    rd_word[i*LW +: LW] = wr_up.data[i*LW +: LW];
                end
            end
        end
    end

    // Output drive: read data for the data phase, else released
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dq_out  <= '0;
            dq_oe_n <= 1'b1;
        end else begin
            // [RQ15] Enable forces release
            if (oe_s2) begin
                dq_oe_n <= 1'b1;
            end else if (edge_on) begin
                // [RQ10] Release after deselect
                dq_oe_n <= (op_now != SBS_READ);
            end
            if (edge_on && op_now == SBS_READ) begin
                // [RQ15] Read word flows
                dq_out <= rd_word;
            end
        end
    end

    // Stall indication to the outside
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_stall <= 1'b0;
        end else begin
            wr_stall <= stall;
        end
    end

    // Checks
    AST_SUSPEND_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        sus_s2 |=> (op_reg == $past(op_reg)) && (cnt_reg == $past(cnt_reg))) // [RQ8]
        else $error("suspend did not hold state");
    AST_LOAD_CLEARS: assert property (@(posedge clk_sys) disable iff (!nrst)
        (edge_on && load) |=> cnt_reg == '0) // [RQ2]
        else $error("load did not end burst");
    AST_DESEL_IDLE: assert property (@(posedge clk_sys) disable iff (!nrst)
        (edge_on && load && !selected) |=> op_reg == SBS_IDLE) // [RQ9]
        else $error("deselect not taken");
    AST_WRITE_START: assert property (@(posedge clk_sys) disable iff (!nrst)
        (edge_on && load && selected && !rw_s2) |=> op_reg == SBS_WRITE) // [RQ5]
        else $error("write not started");
    AST_DIR_FIXED: assert property (@(posedge clk_sys) disable iff (!nrst)
        (edge_on && !load && op_reg != SBS_IDLE) |=> op_reg == $past(op_reg)) // [RQ3]
        else $error("burst direction changed");
    AST_HIGH_BITS: assert property (@(posedge clk_sys) disable iff (!nrst)
        (op_reg != SBS_IDLE) |-> cur_addr[AW-1:SBS_BURST_W] == base_reg[AW-1:SBS_BURST_W]) // [RQ1]
        else $error("burst touched upper address");
    AST_BUS_RELEASE: assert property (@(posedge clk_sys) disable iff (!nrst)
        (edge_on && op_now != SBS_READ) |=> dq_oe_n) // [RQ10]
        else $error("bus not released");
    AST_OE_FORCE: assert property (@(posedge clk_sys) disable iff (!nrst)
        oe_s2 |=> dq_oe_n) // [RQ15]
        else $error("output enable ignored");
    AST_WR_CAPTURE: assert property (@(posedge clk_sys) disable iff (!nrst)
        (edge_on && op_now == SBS_WRITE) |=> ##[0:3] wr_up.valid) // [RQ13]
        else $error("write data not captured");
endmodule
`default_nettype wire

// File: verification/sbsram_ctl_model.sv
// Purpose: Controller-side model that drives the memory pins
// Assumes: Pins change just after the rising edge of clk_sys
// Notes:   Data lines carry a changing pattern when no write is due
`timescale 1ns/1ps
`default_nettype none
module sbsram_ctl_model
    import sbsram_pkg::*;
(
    input  wire logic                  clk_sys,
    output var  logic [SBS_ADDR_W-1:0] addr_in,
    output var  logic                  rd_wr_n,
    output var  logic                  advance_or_load_select,
    output var  logic                  clock_suspend_n,
    output var  logic                  chip_select_a_n,
    output var  logic                  chip_select_c_n,
    output var  logic                  chip_select_b,
    output var  logic                  burst_order_select,
    output var  logic [SBS_LANES-1:0]  lane_wr_n,
    output var  logic                  out_enable_n,
    output var  logic [SBS_DATA_W-1:0] dq_in
);
    logic [SBS_DATA_W-1:0] pend;

    // Idle levels: deselected load, running clock
    initial begin
        {addr_in, rd_wr_n, advance_or_load_select, clock_suspend_n} = {17'h0, 3'h4};
        {chip_select_b, chip_select_c_n, chip_select_a_n} = 3'h3;
        {burst_order_select, out_enable_n} = 2'h0;
        lane_wr_n = 4'hf;
        dq_in = 36'h0;
        pend = 36'h5_a5a5_a5a5;
    end

    task automatic cyc(input logic adv, input logic rw, input logic [SBS_ADDR_W-1:0] a,
                       input logic [SBS_LANES-1:0] ln, input logic [SBS_DATA_W-1:0] wd,
                       input logic [2:0] cs, input logic sus);
        @(posedge clk_sys);
        advance_or_load_select <= adv;
        rd_wr_n <= rw;
        addr_in <= a;
        lane_wr_n <= ln;
        {chip_select_b, chip_select_c_n, chip_select_a_n} <= cs;
        clock_suspend_n <= sus;
        dq_in <= pend;
        pend = wd;
    endtask

    // Static mode pins
    task automatic mode(input logic ord, input logic oe_n);
        @(posedge clk_sys);
        burst_order_select <= ord;
        out_enable_n <= oe_n;
    endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Purpose: Self-checking bench for the burst memory core
// Assumes: Controller model drives pins; reads seen on dq_out
// Notes:   Monitor queues every driven word at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb
    import sbsram_pkg::*;
;
    logic clk_sys, nrst, rd_wr_n, adv, sus_n, cs_a_n, cs_c_n, cs_b, ord, oe_n, dq_oe_n, wr_stall;
    logic [SBS_ADDR_W-1:0] addr_in;
    logic [SBS_LANES-1:0]  lane_wr_n;
    logic [SBS_DATA_W-1:0] dq_in, dq_out, seq;
    logic [SBS_DATA_W-1:0] mem [64];
    logic [SBS_DATA_W-1:0] got [$];
    logic [SBS_DATA_W-1:0] exq [$];
    int n_mismatch, num_checks;

    sbsram_core #(.DEPTH(64)) dut (.clk_sys(clk_sys), .nrst(nrst), .addr_in(addr_in),
        .rd_wr_n(rd_wr_n), .advance_or_load_select(adv), .clock_suspend_n(sus_n),
        .chip_select_a_n(cs_a_n), .chip_select_c_n(cs_c_n), .chip_select_b(cs_b),
        .burst_order_select(ord), .lane_wr_n(lane_wr_n), .out_enable_n(oe_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wr_stall(wr_stall));
    sbsram_ctl_model ctl (.clk_sys(clk_sys), .addr_in(addr_in), .rd_wr_n(rd_wr_n),
        .advance_or_load_select(adv), .clock_suspend_n(sus_n), .chip_select_a_n(cs_a_n),
        .chip_select_c_n(cs_c_n), .chip_select_b(cs_b), .burst_order_select(ord),
        .lane_wr_n(lane_wr_n), .out_enable_n(oe_n), .dq_in(dq_in));

    // Clock
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Collect words the device drives
    always @(negedge clk_sys) begin
        if (dq_oe_n === 1'h0) got.push_back(dq_out);
    end

    task automatic check(input string what, input logic [SBS_DATA_W-1:0] seen,
                         input logic [SBS_DATA_W-1:0] exp_v);
        num_checks++;
        if (seen !== exp_v) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp_v, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [SBS_ADDR_W-1:0] ea(input logic [SBS_ADDR_W-1:0] b, input int i,
                                                 input logic o);
        logic [1:0] k;
        k = i[1:0];
        return {b[SBS_ADDR_W-1:2], o ? (b[1:0] ^ k) : (b[1:0] + k)};
    endfunction

    // Burst of n beats; read/write flipped on advance beats
    task automatic burst(input logic rw, input logic [SBS_ADDR_W-1:0] b, input int n,
                         input logic o, input logic [SBS_LANES-1:0] ln0, input int sus_at);
        logic [SBS_ADDR_W-1:0] a;
        logic [SBS_LANES-1:0]  ln;
        ln = ln0;
        for (int i = 0; i < n; i++) begin
            a = ea(b, i, o);
            seq = seq + 36'h1_0204_0801;
            if (i == sus_at) ctl.cyc(1'h1, ~rw, b, ln, ~ctl.pend, 3'h4, 1'h1);
            ctl.cyc(i != 0, rw ^ (i != 0), b, ln, rw ? ~ctl.pend : seq, 3'h4, 1'h0);
            if (rw) exq.push_back(mem[a[5:0]]);
            else for (int l = 0; l < SBS_LANES; l++)
                if (!ln[l]) mem[a[5:0]][l*SBS_LANE_W +: SBS_LANE_W] = seq[l*SBS_LANE_W +: SBS_LANE_W];
            ln = {ln[SBS_LANES-2:0], ln[SBS_LANES-1]};
        end
    endtask

    task automatic idle(input logic [2:0] cs, input int k);
        repeat (k) ctl.cyc(1'h0, 1'h1, 17'h0, 4'hf, ~ctl.pend, cs, 1'h0);
    endtask

    // Deselect, then compare collected words with the model
    task automatic settle(input logic [2:0] cs, input int dup);
        idle(cs, 6);
        check("beat count", 36'(got.size()), 36'(exq.size() + dup));
        check("bus released", {35'h0, dq_oe_n}, 36'h1);
        for (int i = got.size() - 1; i > 0; i--)
            if (dup != 0 && got[i] === got[i-1]) got.delete(i);
        for (int i = 0; i < exq.size(); i++) check("read word", got[i], exq[i]);
        got.delete();
        exq.delete();
    endtask

    // Watchdog
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        $display("[ERR] watchdog expected done seen timeout");
        finish_test();
    end

    // Main sequence
    initial begin
        nrst = 1'h0;
        seq = 36'h0;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'h1;
        check("oe after reset", {35'h0, dq_oe_n}, 36'h1);
        idle(3'h5, 3);
        got.delete();
        burst(1'h0, 17'h10, 4, 1'h0, 4'h0, -1);
        // Order pin is still low here, so the model uses the linear order
        burst(1'h0, 17'h11, 4, 1'h0, 4'h6, -1);
        idle(3'h5, 3);
        burst(1'h1, 17'h11, 4, 1'h0, 4'hf, -1);
        settle(3'h5, 0);
        ctl.mode(1'h1, 1'h0);
        burst(1'h1, 17'h13, 4, 1'h1, 4'hf, -1);
        settle(3'h6, 0);
        burst(1'h1, 17'h12, 2, 1'h1, 4'hf, -1);
        burst(1'h1, 17'h10, 4, 1'h1, 4'hf, -1);
        settle(3'h0, 0);
        burst(1'h0, 17'h20, 1, 1'h0, 4'h0, -1);
        burst(1'h1, 17'h10, 1, 1'h0, 4'hf, -1);
        burst(1'h1, 17'h20, 1, 1'h0, 4'hf, -1);
        settle(3'h5, 0);
        ctl.mode(1'h0, 1'h0);
        burst(1'h1, 17'h10, 4, 1'h0, 4'hf, 2);
        settle(3'h5, 1);
        for (int j = 0; j < 3; j++) begin
            ctl.cyc(1'h0, 1'h1, 17'h10, 4'hf, ~ctl.pend,
                    (j == 0) ? 3'h5 : ((j == 1) ? 3'h6 : 3'h0), 1'h0);
            settle(3'h5, 0);
        end
        ctl.mode(1'h0, 1'h1);
        burst(1'h1, 17'h10, 4, 1'h0, 4'hf, -1);
        exq.delete();
        settle(3'h5, 0);
        check("write stall", {35'h0, wr_stall}, 36'h0);
        finish_test();
    end
endmodule
`default_nettype wire
